// *** rtl/vsrc_pkg.sv ***
package vsrc_pkg;
	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] range_off      = 8'h00;
	localparam logic [7:0] limit_off      = 8'h04;
	localparam logic [7:0] control_off    = 8'h08;
	localparam logic [7:0] amplitude_off  = 8'h0c;
	localparam logic [7:0] status_off     = 8'h10;
	localparam logic [7:0] rise_off       = 8'h14;
	localparam logic [7:0] fall_off       = 8'h18;
	localparam logic [7:0] event_base_off = 8'h20;
	localparam int         event_regs     = 6;
	// ****************************************
	// field positions and values
	// ****************************************
	localparam int          ctl_limit_en_bit = 0;
	localparam int          ctl_lo_tie_bit   = 1;
	localparam int          ctl_series_bit   = 2;
	localparam int          sts_compl_bit    = 0;
	localparam int          sts_conflict_bit = 1;
	localparam int          sts_range_bit    = 2;
	localparam logic [10:0] low_range_volts  = 11'h064;
	localparam logic [10:0] max_volts        = 11'h3e8;
	localparam logic [10:0] limit_reset      = 11'h3e8;
	localparam logic [10:0] limit_min        = 11'h000;
	localparam logic [10:0] range_dflt       = 11'h064;
	localparam logic [10:0] range_max_sel    = 11'h3e8;
	// keyword codes written in bits 13:12 of range and limit
	localparam logic [1:0]  kw_value = 2'h0;
	localparam logic [1:0]  kw_dflt  = 2'h1;
	localparam logic [1:0]  kw_min   = 2'h2;
	localparam logic [1:0]  kw_max   = 2'h3;
	localparam logic [11:0] amp_reset = 12'h000;

	typedef struct packed {
		logic        limit_en;
		logic        lo_tie;
		logic        series_r;
	} ctl_t;

	typedef struct packed {
		logic        high_range;
		logic [10:0] limit;
		logic signed [11:0] amplitude;
	} src_t;
endpackage : vsrc_pkg

// *** rtl/vsource_config_status_events.sv ***
`timescale 1ns/1ns
// Contract
// - a range value up to 100 picks low range, above 100 picks 1000V range
// - refuse low range while amplitude magnitude exceeds 100; flag conflict
// - range accepts 0..1000; default and minimum give 100V, maximum 1000V
// - limit accepts 0..1000; default and maximum 1000V, minimum 0V; readable
// - limit is a magnitude applying to both polarities
// - limit only acts while enabled; otherwise range bounds output
// - limit enable 0 off, 1 on; readable
// - enabling limit while amplitude exceeds limit raises conflict
// - lo tie switch closed on 1, open on 0; readable
// - series resistor inserted when enabled, normal 1mA limit otherwise
// - compliance reads 1 at current compliance, else 0
// - six event registers each readable separately
// - event register read returns its set bits as a binary value
// - reading an event register clears its bits
// - rising filter sets event bit when condition becomes true
// - falling filter sets event bit when condition becomes false
// - amplitude beyond an enabled limit is clamped to the limit
// - amplitude beyond low range while on it raises conflict
module vsource_config_status_events #(
	parameter int ev_width = 16
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic [vsrc_pkg::event_regs*ev_width-1:0] cond_in,
	input  wire logic                compliance_in,
	output logic                     high_range,
	output logic      [10:0]         limit_bound,
	output logic signed [11:0]       amplitude,
	output logic                     lo_tie_control,
	output logic                     series_resistor_limit,
	output logic                     conflict
);
	localparam int event_regs_w = vsrc_pkg::event_regs * ev_width;

	// ****************************************
	// input synchronisers
	// ****************************************
	logic [event_regs_w-1:0] cond_s1_r, cond_s2_r, cond_d_r;
	logic [event_regs_w-1:0] cond_s1_nxt, cond_s2_nxt, cond_d_nxt;
	logic                    compl_s1_r, compl_s2_r;
	logic                    compl_s1_nxt, compl_s2_nxt;

	always_comb
	begin
		cond_s1_nxt  = cond_in;
		cond_s2_nxt  = cond_s1_r;
		cond_d_nxt   = cond_s2_r;
		compl_s1_nxt = compliance_in;
		compl_s2_nxt = compl_s1_r;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cond_s1_r  <= '0;
			cond_s2_r  <= '0;
			cond_d_r   <= '0;
			compl_s1_r <= 1'b0;
			compl_s2_r <= 1'b0;
		end
		else
		begin
			cond_s1_r  <= cond_s1_nxt;
			cond_s2_r  <= cond_s2_nxt;
			cond_d_r   <= cond_d_nxt;
			compl_s1_r <= compl_s1_nxt;
			compl_s2_r <= compl_s2_nxt;
		end
	end

	// ****************************************
	// apb decode
	// ****************************************
	logic       acc, wr, rd;
	logic [2:0] ev_idx;
	logic       ev_hit;

	assign acc    = psel && penable;
	assign wr     = acc && pwrite;
	assign rd     = acc && !pwrite;
	assign pready = 1'b1;
	assign ev_hit = (paddr >= vsrc_pkg::event_base_off) &&
	                (paddr < vsrc_pkg::event_base_off + 8'(4 * vsrc_pkg::event_regs)) &&
	                (paddr[1:0] == 2'h0);
	assign ev_idx = 3'((paddr - vsrc_pkg::event_base_off) >> 2);

	// ****************************************
	// source configuration
	// ****************************************
	vsrc_pkg::src_t src_r, src_nxt;
	vsrc_pkg::ctl_t ctl_r, ctl_nxt;
	logic           conflict_r, conflict_nxt;
	logic [10:0]    amp_mag, req_val, req_mag, bound;
	logic signed [11:0] req_amp;

	// magnitude makes the limit symmetric about zero
	assign amp_mag = src_r.amplitude[11] ? 11'(-src_r.amplitude) : 11'(src_r.amplitude);
	assign req_amp = pwdata[11:0];
	assign req_mag = req_amp[11] ? 11'(-req_amp) : 11'(req_amp);
	// range bounds output unless the limit is enabled and below the range bound
	assign bound   = (ctl_r.limit_en && src_r.limit < (src_r.high_range ?
	                 vsrc_pkg::max_volts : vsrc_pkg::low_range_volts)) ? src_r.limit :
	                 (src_r.high_range ? vsrc_pkg::max_volts : vsrc_pkg::low_range_volts);

	always_comb
	begin
		src_nxt      = src_r;
		ctl_nxt      = ctl_r;
		conflict_nxt = conflict_r;
		req_val      = pwdata[10:0];
		if (wr)
		begin
			unique case (paddr)
			vsrc_pkg::range_off:
			begin
				unique case (pwdata[13:12])
				vsrc_pkg::kw_dflt: req_val = vsrc_pkg::range_dflt;
				vsrc_pkg::kw_min:  req_val = vsrc_pkg::range_dflt;
				vsrc_pkg::kw_max:  req_val = vsrc_pkg::range_max_sel;
				default:           req_val = (pwdata[10:0] > vsrc_pkg::max_volts) ?
				                             vsrc_pkg::max_volts : pwdata[10:0];
				endcase
				if (req_val <= vsrc_pkg::low_range_volts)
				begin
					if (amp_mag > vsrc_pkg::low_range_volts)
						conflict_nxt = 1'b1;
					else
						src_nxt.high_range = 1'b0;
				end
				else
					src_nxt.high_range = 1'b1;
			end
			vsrc_pkg::limit_off:
			begin
				unique case (pwdata[13:12])
				vsrc_pkg::kw_dflt: src_nxt.limit = vsrc_pkg::limit_reset;
				vsrc_pkg::kw_min:  src_nxt.limit = vsrc_pkg::limit_min;
				vsrc_pkg::kw_max:  src_nxt.limit = vsrc_pkg::max_volts;
				default:           src_nxt.limit = (pwdata[10:0] > vsrc_pkg::max_volts) ?
				                                   vsrc_pkg::max_volts : pwdata[10:0];
				endcase
			end
			vsrc_pkg::control_off:
			begin
				ctl_nxt.limit_en = pwdata[vsrc_pkg::ctl_limit_en_bit];
				ctl_nxt.lo_tie   = pwdata[vsrc_pkg::ctl_lo_tie_bit];
				ctl_nxt.series_r = pwdata[vsrc_pkg::ctl_series_bit];
				if (pwdata[vsrc_pkg::ctl_limit_en_bit] && !ctl_r.limit_en &&
				    amp_mag > src_r.limit)
					conflict_nxt = 1'b1;
			end
			vsrc_pkg::amplitude_off:
			begin
				if (!src_r.high_range && req_mag > vsrc_pkg::low_range_volts)
					conflict_nxt = 1'b1;
				else if (req_mag > bound)
					// clamp keeps the sign, so limit holds in both polarities
					src_nxt.amplitude = req_amp[11] ? -12'(bound) : 12'(bound);
				else
					src_nxt.amplitude = req_amp;
			end
			vsrc_pkg::status_off:
				if (pwdata[vsrc_pkg::sts_conflict_bit])
					conflict_nxt = 1'b0;
			default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			src_r      <= '{1'b0, vsrc_pkg::limit_reset, vsrc_pkg::amp_reset};
			ctl_r      <= '0;
			conflict_r <= 1'b0;
		end
		else
		begin
			src_r      <= src_nxt;
			ctl_r      <= ctl_nxt;
			conflict_r <= conflict_nxt;
		end
	end

	assign high_range            = src_r.high_range;
	assign limit_bound           = bound;
	assign amplitude             = src_r.amplitude;
	assign lo_tie_control        = ctl_r.lo_tie;
	assign series_resistor_limit = ctl_r.series_r;
	assign conflict              = conflict_r;

	// ****************************************
	// transition filters and event registers
	// ****************************************
	logic [event_regs_w-1:0] rising_edge_filter_r, rising_edge_filter_nxt;
	logic [event_regs_w-1:0] falling_edge_filter_r, falling_edge_filter_nxt;
	logic [event_regs_w-1:0] ev_r, ev_nxt, hit;
	logic [2:0]              filt_idx;

	// filter writes pick one event register by data bits 18:16
	assign filt_idx = pwdata[18:16];
	assign hit = (rising_edge_filter_r & cond_s2_r & ~cond_d_r) |
	             (falling_edge_filter_r & ~cond_s2_r & cond_d_r);

	genvar g;
	generate
		for (g = 0; g < vsrc_pkg::event_regs; g++)
		begin : g_ev
			always_comb
			begin
				rising_edge_filter_nxt[g*ev_width +: ev_width] =
					rising_edge_filter_r[g*ev_width +: ev_width];
				falling_edge_filter_nxt[g*ev_width +: ev_width] =
					falling_edge_filter_r[g*ev_width +: ev_width];
				if (wr && paddr == vsrc_pkg::rise_off && filt_idx == 3'(g))
					rising_edge_filter_nxt[g*ev_width +: ev_width] = pwdata[ev_width-1:0];
				if (wr && paddr == vsrc_pkg::fall_off && filt_idx == 3'(g))
					falling_edge_filter_nxt[g*ev_width +: ev_width] = pwdata[ev_width-1:0];
				// set beats the clearing read so no event is lost
				ev_nxt[g*ev_width +: ev_width] =
					((rd && ev_hit && ev_idx == 3'(g)) ? '0 :
					 ev_r[g*ev_width +: ev_width]) | hit[g*ev_width +: ev_width];
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rising_edge_filter_r  <= '1;
			falling_edge_filter_r <= '0;
			ev_r                  <= '0;
		end
		else
		begin
			rising_edge_filter_r  <= rising_edge_filter_nxt;
			falling_edge_filter_r <= falling_edge_filter_nxt;
			ev_r                  <= ev_nxt;
		end
	end

	// ****************************************
	// read mux
	// ****************************************
	always_comb
	begin
		prdata  = '0;
		pslverr = 1'b0;
		if (rd)
		begin
			if (ev_hit)
				prdata[ev_width-1:0] = ev_r[ev_idx*ev_width +: ev_width];
			else
			begin
				unique case (paddr)
				vsrc_pkg::range_off:     prdata[10:0] = src_r.high_range ?
				                         vsrc_pkg::max_volts : vsrc_pkg::low_range_volts;
				vsrc_pkg::limit_off:     prdata[10:0] = src_r.limit;
				vsrc_pkg::control_off:   prdata[2:0]  = {ctl_r.series_r, ctl_r.lo_tie,
				                                          ctl_r.limit_en};
				vsrc_pkg::amplitude_off: prdata[11:0] = src_r.amplitude;
				vsrc_pkg::status_off:    prdata[2:0]  = {src_r.high_range, conflict_r,
				                                          compl_s2_r};
				default:                 pslverr = 1'b1;
				endcase
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_clear_read: assert property (@(posedge pclk) disable iff (!presetn)
		(rd && ev_hit && ev_idx == 3'h0 && hit[ev_width-1:0] == '0)
		|=> ev_r[ev_width-1:0] == '0)
		else $error("event register not cleared by read");
	a_event_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		(ev_r[0] && !(rd && ev_hit && ev_idx == 3'h0)) |=> ev_r[0])
		else $error("event bit lost without read");
	a_rise_sets: assert property (@(posedge pclk) disable iff (!presetn)
		(rising_edge_filter_r[0] && cond_s2_r[0] && !cond_d_r[0]) |=> ev_r[0])
		else $error("rising event not captured");
	a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		(rd && ev_hit && ev_idx == 3'h0 && hit[0]) |=> ev_r[0])
		else $error("event lost at clearing read");
	a_amp_bound: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(src_r.amplitude) |-> amp_mag <= $past(bound))
		else $error("amplitude above bound");
	a_low_guard: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == vsrc_pkg::range_off && amp_mag > vsrc_pkg::low_range_volts)
		|=> high_range == $past(high_range))
		else $error("low range taken with high amplitude");
	a_lim_conflict: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == vsrc_pkg::control_off && pwdata[0] && !ctl_r.limit_en &&
		 amp_mag > src_r.limit) |=> conflict)
		else $error("limit enable conflict missed");
	a_high_pick: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == vsrc_pkg::range_off && pwdata[13:12] == vsrc_pkg::kw_value &&
		 pwdata[10:0] > vsrc_pkg::low_range_volts) |=> high_range)
		else $error("high range not selected");
	a_lo_tie: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == vsrc_pkg::control_off) |=> lo_tie_control == $past(pwdata[1]))
		else $error("lo tie not following write");
endmodule : vsource_config_status_events

// *** dv/vsrc_host.sv ***
`timescale 1ns/1ns
module vsrc_host (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	output logic             hung
);
	// ****************************************
	// host side: one apb transfer per call
	// ****************************************
	initial
	begin
		psel    = 1'h0;
		penable = 1'h0;
		pwrite  = 1'h0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		hung    = 1'h0;
	end

	// query sent, reply taken at the edge that shows pready, or after 64 waiting edges
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'h1 && n < 64);
		if (pready !== 1'h1)
			hung <= 1'h1;
		q       = prdata;
		err     = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : xfer
endmodule : vsrc_host

// *** dv/vsource_config_status_events_test.sv ***
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin n_mismatch++; \
	$display("unexpected %s exp %h got %h", nm, ex, gt); end end
module vsource_config_status_events_test;
	logic               pclk = 1'h0;
	logic               presetn = 1'h0;
	logic [95:0]        cond_in = '0;
	logic               compliance_in = 1'h0;
	logic               psel, penable, pwrite, pready, pslverr, hung, e;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, q;
	logic               high_range, lo_tie_control, series_resistor_limit, conflict;
	logic [10:0]        limit_bound;
	logic signed [11:0] amplitude;
	int                 n_mismatch = 0;
	int                 cmp_count = 0;
	int                 v, b;
	integer             seed = 32'hcadf;

	always #4 pclk = ~pclk;

	vsource_config_status_events dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cond_in(cond_in), .compliance_in(compliance_in), .high_range(high_range),
		.limit_bound(limit_bound), .amplitude(amplitude), .lo_tie_control(lo_tie_control),
		.series_resistor_limit(series_resistor_limit), .conflict(conflict)
	);
	vsrc_host host_u (
		.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .hung(hung)
	);

	// ****************************************
	// helpers
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host_u.xfer(1'h1, a, d, q, e);
		// registered outputs settle after the commit edge
		@(negedge pclk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		host_u.xfer(1'h0, a, 32'h0, q, e);
	endtask : rd
	function automatic logic [11:0] clamp(int x, int l);
		return 12'(x > l ? l : (x < -l ? -l : x));
	endfunction : clamp
	function automatic logic [10:0] rng(int x);
		return x <= 100 ? 11'h064 : 11'h3e8;
	endfunction : rng
	// three sync/detect edges, so five cycles leaves margin either side
	task automatic pulse(int i);
		@(posedge pclk);
		cond_in[i] <= 1'h1;
		repeat (5) @(posedge pclk);
		cond_in[i] <= 1'h0;
		repeat (5) @(posedge pclk);
	endtask : pulse
	task automatic finish_test;
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test

	always @(posedge hung)
	begin
		n_mismatch++;
		finish_test();
	end
	initial
	begin
		repeat (50000) @(posedge pclk);
		n_mismatch++;
		finish_test();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		rd(vsrc_pkg::range_off);
		`CHK("range", vsrc_pkg::range_dflt, q[10:0])
		rd(vsrc_pkg::limit_off);
		`CHK("limit", vsrc_pkg::limit_reset, q[10:0])
		for (int i = 0; i < 8; i++)
		begin
			v = i == 0 ? 100 : (i == 1 ? 101 : (($random(seed) & 32'h7fffffff) % 1001));
			wr(vsrc_pkg::range_off, 32'(v));
			rd(vsrc_pkg::range_off);
			`CHK("range", rng(v), q[10:0])
			`CHK("high", 1'(v > 100), high_range)
		end
		for (int k = 1; k < 4; k++)
		begin
			wr(vsrc_pkg::range_off, 32'(k) << 12);
			rd(vsrc_pkg::range_off);
			`CHK("range kw", (k == 3 ? 11'h3e8 : 11'h064), q[10:0])
			wr(vsrc_pkg::limit_off, 32'(k) << 12);
			rd(vsrc_pkg::limit_off);
			`CHK("limit kw", (k == 2 ? 11'h000 : 11'h3e8), q[10:0])
		end
		wr(vsrc_pkg::limit_off, 32'h4b);
		wr(vsrc_pkg::range_off, 32'h64);
		wr(vsrc_pkg::amplitude_off, 32'h96);
		`CHK("conflict", 1'h1, conflict)
		`CHK("amp kept", 12'h000, amplitude)
		wr(vsrc_pkg::status_off, 32'h2);
		wr(vsrc_pkg::range_off, 32'h3e8);
		wr(vsrc_pkg::amplitude_off, 32'h1f4);
		wr(vsrc_pkg::range_off, 32'h32);
		`CHK("range kept", 1'h1, high_range)
		`CHK("conflict", 1'h1, conflict)
		wr(vsrc_pkg::status_off, 32'h2);
		wr(vsrc_pkg::control_off, 32'h1);
		`CHK("conflict", 1'h1, conflict)
		`CHK("bound", 11'h04b, limit_bound)
		for (int i = 0; i < 6; i++)
		begin
			v = i == 0 ? -200 : $random(seed) % 1001;
			wr(vsrc_pkg::amplitude_off, 32'(v));
			`CHK("amp", clamp(v, 75), amplitude)
		end
		wr(vsrc_pkg::control_off, 32'h0);
		`CHK("bound", 11'h3e8, limit_bound)
		for (int i = 0; i < 8; i++)
		begin
			wr(vsrc_pkg::control_off, 32'(i));
			`CHK("lo tie", 1'(i >> 1), lo_tie_control)
			`CHK("series", 1'(i >> 2), series_resistor_limit)
			rd(vsrc_pkg::control_off);
			`CHK("control", 3'(i), q[2:0])
		end
		for (int c = 0; c < 2; c++)
		begin
			@(posedge pclk);
			compliance_in <= 1'(c);
			repeat (4) @(posedge pclk);
			rd(vsrc_pkg::status_off);
			`CHK("compliance", 1'(c), q[0])
		end
		rd(8'h1c);
		`CHK("unmapped", 1'h1, e)
		for (int k = 0; k < 6; k++)
		begin
			b = ($random(seed) & 32'h7fff) % 15;
			pulse(16 * k + b);
			rd(vsrc_pkg::event_base_off + 8'(4 * k));
			`CHK("event", 32'h1 << b, q)
			rd(vsrc_pkg::event_base_off + 8'(4 * k));
			`CHK("cleared", 32'h0, q)
			wr(vsrc_pkg::rise_off, {13'h0, 3'(k), 16'h0});
			wr(vsrc_pkg::fall_off, {13'h0, 3'(k), 16'(1 << b)});
			pulse(16 * k + b);
			rd(vsrc_pkg::event_base_off + 8'(4 * k));
			`CHK("fall event", 32'h1 << b, q)
			wr(vsrc_pkg::rise_off, {13'h0, 3'(k), 16'hffff});
			wr(vsrc_pkg::fall_off, {13'h0, 3'(k), 16'h0});
		end
		finish_test();
	end
endmodule : vsource_config_status_events_test
